// ---- rtl/startup_params.svh ----
// Constants for the start-up delay, ramp and timeout sequencer
`ifndef STARTUP_PARAMS_SVH
`define STARTUP_PARAMS_SVH
// ****************************************************************
// Command codes
// ****************************************************************
`define STU_CMD_DELAY    8'h60
`define STU_CMD_RAMP     8'h61
`define STU_CMD_TIMEOUT  8'h62
// ****************************************************************
// Word layout
// ****************************************************************
`define STU_EXP_MSB      15
`define STU_EXP_LSB      11
`define STU_MAN_MSB      10
`define STU_MAN_LSB      0
`define STU_RESP_MSB     7
`define STU_RESP_LSB     6
`define STU_RDLY_MSB     2
`define STU_RDLY_LSB     0
// ****************************************************************
// Reset values (exponent fixed, mantissa a plain default)
// ****************************************************************
`define STU_DELAY_RST    16'hF800
`define STU_RAMP_RST     16'hF00C
`define STU_TIMEOUT_RST  16'hF800
`define STU_DELAY_RST_Q  9'h000
`define STU_RAMP_RST_Q   7'h0C
`define STU_TIMEOUT_RST_Q 9'h000
`define STU_HALF_EXP     5'h1F
// ****************************************************************
// Ranges in quarter milliseconds
// ****************************************************************
`define STU_DELAY_MAXQ   510
`define STU_DELAY_STEPQ  2
`define STU_RAMP_MAXQ    127
`define STU_RAMP_STEPQ   1
`define STU_TIMEOUT_MAXQ 508
`define STU_TIMEOUT_STEPQ 2
`define STU_RAMP_MINQ    7'h02
`define STU_TICKS_PER_MS 4
`define STU_THR_SHIFT    3
// ****************************************************************
// Timing
// ****************************************************************
`define STU_CLK_NS       8
`define STU_STEP_NS      250000
`define STU_INIT_NS      100000
`define STU_STEP_CYC     ((`STU_STEP_NS) / (`STU_CLK_NS))
`define STU_INIT_CYC     ((`STU_INIT_NS + `STU_CLK_NS - 1) / (`STU_CLK_NS))
`endif

// ---- rtl/startup_pkg.sv ----
// Types shared by the start-up sequencer modules
`default_nettype none
package startup_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RAMP  = 2'b10,
    ST_REG   = 2'b11
  } seq_st_t;

  typedef struct packed {
    seq_st_t     st;
    logic [15:0] dly_w;
    logic [15:0] ramp_w;
    logic [15:0] to_w;
    logic [8:0]  dly_q;
    logic [6:0]  ramp_q;
    logic [8:0]  to_q;
    logic        restore_pend;
    logic        start_d;
    logic [13:0] init_cnt;
    logic        init_done;
    logic [8:0]  tcnt;
    logic [8:0]  tocnt;
    logic        to_run;
    logic [22:0] total;
    logic [22:0] err;
    logic [15:0] ref_v;
    logic [15:0] telem;
    logic        ramp;
    logic        uv_en;
    logic        sw;
    logic        st_other;
    logic        st_vout;
    logic        st_to;
    logic        st_cml;
    logic        alert;
    logic        shut;
    logic        rpend;
    logic [4:0]  rcnt;
    logic [15:0] rd;
    logic        ack;
  } seq_reg_t;

  typedef struct packed {
    logic [14:0] cnt;
    logic        tick;
  } div_reg_t;
endpackage
`default_nettype wire

// ---- rtl/tick_if.sv ----
// Step tick carried from the divider to the sequencer
`timescale 1ns/10ps
`default_nettype none
interface tick_if;
  logic tick;
  logic restart;
  modport src (input restart, output tick);
  modport dst (output restart, input tick);
endinterface
`default_nettype wire

// ---- rtl/tick_divider.sv ----
// Quarter-millisecond step tick, restartable to align its phase
`timescale 1ns/10ps
`default_nettype none
`include "startup_params.svh"
module tick_divider
  import startup_pkg::*;
#(
  parameter int STEP_CYC = `STU_STEP_CYC
)(
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  tick_if.src       tk
);
  div_reg_t r_r;
  div_reg_t r_nxt;

  always_comb
  begin
    r_nxt      = r_r;
    r_nxt.tick = 1'b0;
    if (tk.restart)
    begin
      r_nxt.cnt = '0;
    end
    else if (r_r.cnt == 15'(STEP_CYC - 1))
    begin
      r_nxt.cnt  = '0;
      r_nxt.tick = 1'b1; // [RQ18]
    end
    else
    begin
      r_nxt.cnt = r_r.cnt + 15'h0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign tk.tick = r_r.tick;
endmodule // tick_divider
`default_nettype wire

// ---- rtl/linear_decode.sv ----
// Signed linear word to quarter-millisecond count, with range check
`timescale 1ns/10ps
`default_nettype none
module linear_decode #(
  parameter int MAXQ  = 510,
  parameter int STEPQ = 2
)(
  input  wire logic [15:0] i_word,
  output logic      [8:0]  o_q,
  output logic             o_ok
);
  logic signed [5:0]  sh;
  logic        [5:0]  nn;
  logic signed [31:0] m;
  logic signed [31:0] v;
  logic               exact;
  logic               big;

  always_comb
  begin
    // Exponent 15:11 and mantissa 10:0, both two's complement [RQ2]
    sh    = $signed({i_word[15], i_word[15:11]}) + 6'sh02;
    m     = {{21{i_word[10]}}, i_word[10:0]};
    nn    = 6'(-sh);
    v     = '0;
    exact = 1'b1;
    big   = 1'b0;
    if (!sh[5])
    begin
      if (sh > 6'sh0A)
        big = (m != 32'sh0);
      else
        v = m <<< sh[3:0];
    end
    else
    begin
      v     = m >>> nn;
      exact = ((v <<< nn) == m);
    end
    // Off-grid, negative or oversized values are refused [RQ6]
    o_ok = exact && !big && !v[31] && (v <= MAXQ) && ((v % STEPQ) == 0);
    o_q  = v[8:0];
  end
endmodule // linear_decode
`default_nettype wire

// ---- rtl/startup_sequencer.sv ----
// Start-up sequencer: turn-on delay, soft-start ramp, start-up timeout
// Overview of operation
// [RQ1] Output starts rising only after the programmed delay from the start condition.
// [RQ2] Settings are 16-bit linear words: exponent 15:11, mantissa 10:0, milliseconds.
// [RQ3] Delay accepts 0 to 127.5 ms in 0.5 ms steps; exponent resets 11111b.
// [RQ4] At least about 100 us passes even with zero delay, for initialisation.
// [RQ5] After power-up or restore the delay snaps to the nearest supported value.
// [RQ6] Out-of-range writes are refused, flagged and signalled to the host.
// [RQ7] Reference slews so the ramp lasts the set time whatever the target; code caps slew at one LSB per clock, so steep ramps run long.
// [RQ8] Ramp accepts 0 to 31.75 ms in 0.25 ms steps; exponent resets 11110b.
// [RQ9] Ramp settings below 0.5 ms run as a 0.5 ms ramp.
// [RQ10] Limited slew resolution may quantise long ramps at high targets.
// [RQ11] At timeout expiry the last telemetry below 87.5% of target is a fault.
// [RQ12] Telemetry lag may let a dip up to 2 ms early cause the fault.
// [RQ13] Timeout accepts 0 to 127 ms in 0.5 ms steps; exponent resets 11111b.
// [RQ14] A zero timeout disables the timeout check.
// [RQ15] Undervoltage check is armed only when the ramp ends.
// [RQ16] Timeout fault sets catch-all, output-voltage and timeout bits, alerts host.
// [RQ17] Response 00 ignore, 01 delayed shutdown if still low, 10 immediate.
// [RQ18] Counters run from a step tick no coarser than the finest step.
`timescale 1ns/10ps
`default_nettype none
`include "startup_params.svh"
module startup_sequencer
  import startup_pkg::*;
#(
  parameter int STEP_CYC = `STU_STEP_CYC,
  parameter int INIT_CYC = `STU_INIT_CYC
)(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_cmd_wr,
  input  wire logic        i_cmd_rd,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_data,
  input  wire logic        i_start_cond,
  input  wire logic        i_restore,
  input  wire logic        i_clear_faults,
  input  wire logic [15:0] i_target_vout,
  input  wire logic [15:0] i_telem_vout,
  input  wire logic        i_telem_valid,
  input  wire logic [7:0]  i_to_response,
  output logic      [15:0] o_rd_data,
  output logic             o_rd_ack,
  output logic      [15:0] o_ref_dac,
  output logic             o_switching,
  output logic             o_ramp_active,
  output logic             o_uv_check_en,
  output logic             o_status_other,
  output logic             o_output_voltage_status,
  output logic             o_status_timeout,
  output logic             o_status_cml,
  output logic             o_alert,
  output logic             o_shutdown
);
  import startup_pkg::*;

  // ****************************************************************
  // Step tick and write-data checkers
  // ****************************************************************
  localparam int MAXQ  [3] = '{`STU_DELAY_MAXQ, `STU_RAMP_MAXQ, `STU_TIMEOUT_MAXQ};
  localparam int STEPQ [3] = '{`STU_DELAY_STEPQ, `STU_RAMP_STEPQ, `STU_TIMEOUT_STEPQ};

  tick_if tk ();
  seq_reg_t   r_r;
  seq_reg_t   r_nxt;
  logic [8:0] wq [3];
  logic       wok [3];
  logic       restart;
  logic [15:0] thr;
  logic [22:0] sum;
  logic        low;

  tick_divider #(.STEP_CYC(STEP_CYC)) u_div (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .tk        (tk.src)
  );

  // Range and step limits per setting [RQ3] [RQ8] [RQ13]
  for (genvar g = 0; g < 3; g++)
  begin : g_dec
    linear_decode #(.MAXQ(MAXQ[g]), .STEPQ(STEPQ[g])) u_dec (
      .i_word (i_cmd_data),
      .o_q    (wq[g]),
      .o_ok   (wok[g])
    );
  end

  assign tk.restart = restart;
  // 87.5% of the commanded voltage [RQ11]
  assign thr = i_target_vout - (i_target_vout >> `STU_THR_SHIFT);
  assign sum = r_r.err + {7'h00, i_target_vout};
  // Compares the last recorded sample, so a dip up to 2 ms old can count [RQ12]
  assign low = (r_r.telem < thr);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    r_nxt   = r_r;
    restart = 1'b0;
    r_nxt.start_d = i_start_cond;
    r_nxt.ack     = 1'b0;
    if (i_telem_valid)
      r_nxt.telem = i_telem_vout; // [RQ12]
    if (i_clear_faults)
    begin
      r_nxt.st_other = 1'b0;
      r_nxt.st_vout  = 1'b0;
      r_nxt.st_to    = 1'b0;
      r_nxt.st_cml   = 1'b0;
    end

    // Register access
    if (i_cmd_rd)
    begin
      r_nxt.ack = 1'b1;
      case (i_cmd_code)
        `STU_CMD_DELAY:   r_nxt.rd = r_r.dly_w;
        `STU_CMD_RAMP:    r_nxt.rd = r_r.ramp_w;
        `STU_CMD_TIMEOUT: r_nxt.rd = r_r.to_w;
        default:          r_nxt.rd = 16'h0000;
      endcase
    end
    if (i_cmd_wr)
    begin
      case (i_cmd_code)
        `STU_CMD_DELAY:
        begin
          if (wok[0])
          begin
            r_nxt.dly_w = i_cmd_data;
            r_nxt.dly_q = wq[0];
          end
          else
            r_nxt.st_cml = 1'b1; // [RQ6]
        end
        `STU_CMD_RAMP:
        begin
          if (wok[1])
          begin
            r_nxt.ramp_w = i_cmd_data;
            r_nxt.ramp_q = wq[1][6:0];
          end
          else
            r_nxt.st_cml = 1'b1; // [RQ6]
        end
        `STU_CMD_TIMEOUT:
        begin
          if (wok[2])
          begin
            r_nxt.to_w = i_cmd_data;
            r_nxt.to_q = wq[2];
          end
          else
            r_nxt.st_cml = 1'b1; // [RQ6]
        end
        default: ;
      endcase
    end
    // Re-encode in half-millisecond form; stored values are already on grid
    if (r_r.restore_pend || i_restore)
    begin
      r_nxt.dly_w = {`STU_HALF_EXP, 3'b000, r_nxt.dly_q[8:1]}; // [RQ5]
      r_nxt.dly_q = {r_nxt.dly_q[8:1], 1'b0};
      r_nxt.restore_pend = 1'b0;
    end

    // Sequence
    case (r_r.st)
      ST_IDLE:
      begin
        if (i_start_cond && !r_r.start_d)
        begin
          restart         = 1'b1;
          r_nxt.st        = ST_DELAY;
          r_nxt.init_cnt  = '0;
          r_nxt.init_done = 1'b0;
          r_nxt.tcnt      = '0;
          r_nxt.shut      = 1'b0;
        end
      end
      ST_DELAY:
      begin
        // Initialisation window overlaps the programmed delay [RQ4]
        if (r_r.init_cnt == 14'(INIT_CYC - 1))
          r_nxt.init_done = 1'b1;
        else
          r_nxt.init_cnt = r_r.init_cnt + 14'h0001;
        if (tk.tick)
          r_nxt.tcnt = r_r.tcnt + 9'h001;
        if (r_r.init_done && (r_r.tcnt >= r_r.dly_q)) // [RQ1]
        begin
          restart       = 1'b1;
          r_nxt.st      = ST_RAMP;
          r_nxt.ramp    = 1'b1;
          r_nxt.sw      = 1'b1;
          r_nxt.ref_v   = '0;
          r_nxt.err     = '0;
          r_nxt.tocnt   = '0;
          r_nxt.to_run  = (r_r.to_q != 9'h000); // [RQ14]
          // Short settings stretched to half a millisecond [RQ9]
          r_nxt.total   = 23'(((r_r.ramp_q < `STU_RAMP_MINQ) ? `STU_RAMP_MINQ
                                                            : r_r.ramp_q) * STEP_CYC);
        end
      end
      ST_RAMP:
      begin
        // One LSB per clock at most, so steep ramps saturate [RQ7] [RQ10]
        if (sum >= r_r.total)
        begin
          r_nxt.err   = sum - r_r.total;
          r_nxt.ref_v = r_r.ref_v + 16'h0001;
        end
        else
          r_nxt.err = sum;
        if (r_r.ref_v >= i_target_vout)
        begin
          r_nxt.st    = ST_REG;
          r_nxt.ramp  = 1'b0;
          r_nxt.ref_v = i_target_vout;
          r_nxt.uv_en = 1'b1; // [RQ15]
        end
      end
      ST_REG:
        r_nxt.ref_v = i_target_vout;
      default:
        r_nxt.st = ST_IDLE;
    endcase

    // Timeout runs from the end of the delay [RQ11]
    // A limit rewritten to zero mid-attempt also stops the check [RQ14]
    if (r_r.to_run && tk.tick && (r_r.to_q != 9'h000))
    begin
      r_nxt.tocnt = r_r.tocnt + 9'h001;
      if (r_nxt.tocnt == r_r.to_q)
      begin
        r_nxt.to_run = 1'b0;
        if (low)
        begin
          r_nxt.st_other = 1'b1; // [RQ16]
          r_nxt.st_vout  = 1'b1;
          r_nxt.st_to    = 1'b1;
          case (i_to_response[`STU_RESP_MSB:`STU_RESP_LSB])
            2'b01:
            begin
              r_nxt.rpend = 1'b1; // [RQ17]
              r_nxt.rcnt  = 5'(i_to_response[`STU_RDLY_MSB:`STU_RDLY_LSB]
                               * `STU_TICKS_PER_MS);
            end
            2'b10:   r_nxt.shut = 1'b1; // [RQ17]
            default: ;
          endcase
        end
      end
    end
    if (r_r.rpend)
    begin
      if (r_r.rcnt == 5'h00)
      begin
        r_nxt.rpend = 1'b0;
        r_nxt.shut  = r_r.shut | low; // [RQ17]
      end
      else if (tk.tick)
        r_nxt.rcnt = r_r.rcnt - 5'h01;
    end

    // Losing the start condition ends the attempt
    if ((r_r.st != ST_IDLE) && !i_start_cond)
    begin
      r_nxt.st     = ST_IDLE;
      r_nxt.sw     = 1'b0;
      r_nxt.ramp   = 1'b0;
      r_nxt.uv_en  = 1'b0;
      r_nxt.ref_v  = '0;
      r_nxt.to_run = 1'b0;
      r_nxt.rpend  = 1'b0;
      r_nxt.shut   = 1'b0;
    end
    if (r_nxt.shut)
    begin
      r_nxt.sw    = 1'b0;
      r_nxt.ramp  = 1'b0;
      r_nxt.ref_v = '0;
    end
    r_nxt.alert = r_nxt.st_other | r_nxt.st_vout | r_nxt.st_to | r_nxt.st_cml; // [RQ16]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r_r              <= '0;
      r_r.dly_w        <= `STU_DELAY_RST;
      r_r.ramp_w       <= `STU_RAMP_RST;
      r_r.to_w         <= `STU_TIMEOUT_RST;
      r_r.dly_q        <= `STU_DELAY_RST_Q;
      r_r.ramp_q       <= `STU_RAMP_RST_Q;
      r_r.to_q         <= `STU_TIMEOUT_RST_Q;
      r_r.restore_pend <= 1'b1;
    end
    else
      r_r <= r_nxt;
  end

  assign o_rd_data        = r_r.rd;
  assign o_rd_ack         = r_r.ack;
  assign o_ref_dac        = r_r.ref_v;
  assign o_switching      = r_r.sw;
  assign o_ramp_active    = r_r.ramp;
  assign o_uv_check_en    = r_r.uv_en;
  assign o_status_other   = r_r.st_other;
  assign o_output_voltage_status    = r_r.st_vout;
  assign o_status_timeout = r_r.st_to;
  assign o_status_cml     = r_r.st_cml;
  assign o_alert          = r_r.alert;
  assign o_shutdown       = r_r.shut;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  delay_min_a: // [RQ4]
    assert property ($rose(o_ramp_active) |-> $past(r_r.init_done))
    else $error("ramp began before initialisation window");
  delay_time_a: // [RQ1]
    assert property ($rose(o_ramp_active) |-> $past(r_r.tcnt) >= $past(r_r.dly_q))
    else $error("ramp began before turn-on delay");
  bad_write_a: // [RQ6]
    assert property (i_cmd_wr && (i_cmd_code == `STU_CMD_RAMP) && !wok[1]
                     && !i_clear_faults |=> o_status_cml && o_alert && $stable(r_r.ramp_w))
    else $error("invalid ramp write not refused");
  ramp_min_a: // [RQ9]
    assert property ($rose(o_ramp_active) |-> r_r.total >= 23'(2 * STEP_CYC))
    else $error("ramp shorter than half a millisecond");
  uv_arm_a: // [RQ15]
    assert property ($rose(o_uv_check_en) |-> $past(o_ramp_active) && !o_ramp_active)
    else $error("undervoltage check armed outside ramp end");
  fault_bits_a: // [RQ16]
    assert property ($rose(o_status_timeout) |-> o_status_other && o_output_voltage_status && o_alert)
    else $error("timeout fault bits incomplete");
  to_off_a: // [RQ14]
    assert property (r_r.to_q == 9'h000 && !$past(i_cmd_wr) |-> !$rose(o_status_timeout))
    else $error("timeout fault with check disabled");
  resp_now_a: // [RQ17]
    assert property ($rose(o_status_timeout) && $past(i_start_cond)
                     && $past(i_to_response[7:6]) == 2'b10 |-> o_shutdown)
    else $error("immediate shutdown missing");
  restore_a: // [RQ5]
    assert property ($past(i_restore) |-> r_r.dly_w[15:11] == `STU_HALF_EXP && !r_r.dly_q[0])
    else $error("restored delay not on half millisecond grid");

  seq_full_c: cover property (o_ramp_active ##[1:1000] o_uv_check_en);
  to_fault_c: cover property ($rose(o_status_timeout));
  bad_wr_c:   cover property ($rose(o_status_cml));
  shut_c:     cover property ($rose(o_shutdown));
endmodule // startup_sequencer
`default_nettype wire

// ---- verif/host_model.sv ----
// Host-side command master for the sequencer's command port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_ack,
  output logic             o_cmd_wr,
  output logic             o_cmd_rd,
  output logic      [7:0]  o_cmd_code,
  output logic      [15:0] o_cmd_data
);
  initial
  begin
    o_cmd_wr   = 1'b0;
    o_cmd_rd   = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_data = 16'h0000;
  end

  task automatic wr(input logic [7:0] code, input logic [15:0] word);
    @(posedge i_sys_clk);
    #1;
    o_cmd_code = code;
    o_cmd_data = word;
    o_cmd_wr   = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_cmd_wr   = 1'b0;
    // Released data shows the inverse, so a stale word is never mistaken for a write
    o_cmd_data = ~word;
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] word, output logic ok);
    int n;
    ok   = 1'b0;
    word = 16'hFFFF;
    @(posedge i_sys_clk);
    #1;
    o_cmd_code = code;
    o_cmd_rd   = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_cmd_rd = 1'b0;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (i_rd_ack === 1'b1)
      begin
        ok   = 1'b1;
        word = i_rd_data;
      end
      else
      begin
        @(posedge i_sys_clk);
        #1;
      end
    end
  endtask
endmodule // host_model
`default_nettype wire

// ---- verif/startup_delay_ramp_timeout_tb_top.sv ----
// Self-checking bench for the start-up sequencer
`timescale 1ns/10ps
`default_nettype none
module startup_delay_ramp_timeout_tb_top;
  import startup_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cmd_wr, cmd_rd, rd_ack, sw, ramp, uv, s_oth, s_vout, s_to, s_cml, alert, shut, ok;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_data, rd_data, ref_dac, rv;
  logic start = 1'b0, restore = 1'b0, clr = 1'b0, tval = 1'b0;
  logic [15:0] target = 16'h0014, telem = 16'h0000;
  logic [7:0]  resp = 8'h00;
  int err_count = 0;
  int tests_run = 0;
  int t_on, t_len;
  logic [7:0]  wc [9] = '{8'h60, 8'h60, 8'h60, 8'h61, 8'h61, 8'h62, 8'h62, 8'h62, 8'h60};
  logic [15:0] ww [9] = '{16'hF900, 16'hF001, 16'hF8FF, 16'hF080, 16'hF07F, 16'hF8FF,
                          16'hFFFF, 16'hF8FE, 16'hF004};
  logic        wbad [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0] regv [4] = '{16'hF800, 16'hF00C, 16'hF800, 16'h0000};
  // Delay, ramp, target, window for ramp start, window for ramp length
  logic [15:0] sd [3] = '{16'hF802, 16'hF800, 16'hF800};
  logic [15:0] sr [3] = '{16'hF000, 16'hF004, 16'hF000};
  logic [15:0] st [3] = '{16'h0014, 16'h0014, 16'h00C8};
  int on_lo [3] = '{80, 8, 8};
  int on_hi [3] = '{84, 12, 12};
  int ln_lo [3] = '{38, 78, 197};
  int ln_hi [3] = '{44, 84, 204};
  // Limit, telemetry, response, fault, shut early, shut late
  logic [15:0] tl [5] = '{16'hF802, 16'hF802, 16'hF802, 16'hF802, 16'hF800};
  logic [15:0] tt [5] = '{16'h0011, 16'h0012, 16'h0011, 16'h0011, 16'h0011};
  logic [7:0]  tr [5] = '{8'h80, 8'h80, 8'h00, 8'h41, 8'h80};
  logic        tf [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic        te [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic        tz [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  always #4 i_sys_clk = ~i_sys_clk;

  startup_sequencer #(.STEP_CYC(20), .INIT_CYC(8)) u_startup_sequencer (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cmd_wr(cmd_wr), .i_cmd_rd(cmd_rd),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data), .i_start_cond(start),
    .i_restore(restore), .i_clear_faults(clr), .i_target_vout(target),
    .i_telem_vout(telem), .i_telem_valid(tval), .i_to_response(resp),
    .o_rd_data(rd_data), .o_rd_ack(rd_ack), .o_ref_dac(ref_dac), .o_switching(sw),
    .o_ramp_active(ramp), .o_uv_check_en(uv), .o_status_other(s_oth),
    .o_output_voltage_status(s_vout), .o_status_timeout(s_to), .o_status_cml(s_cml),
    .o_alert(alert), .o_shutdown(shut));

  host_model u_host_model (
    .i_sys_clk(i_sys_clk), .i_rd_data(rd_data), .i_rd_ack(rd_ack), .o_cmd_wr(cmd_wr),
    .o_cmd_rd(cmd_rd), .o_cmd_code(cmd_code), .o_cmd_data(cmd_data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic nxt(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic test_done;
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic inr(input string nm, input int v, input int lo, input int hi);
    check(nm, {15'h0, (v >= lo && v <= hi)}, 16'h0001);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] c, input logic [15:0] exp);
    u_host_model.rd(c, rv, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH read_ack expected 1 seen 0");
      test_done();
    end
    check(nm, rv, exp);
  endtask

  task automatic pulse_clr;
    clr = 1'b1;
    nxt(1);
    clr = 1'b0;
    nxt(1);
  endtask

  // Bounded waits: a ramp that never starts or never ends ends the run
  task automatic run(input logic [15:0] tel);
    telem = tel;
    tval  = 1'b1;
    nxt(1);
    tval  = 1'b0;
    start = 1'b1;
    t_on  = 0;
    t_len = 0;
    while (ramp !== 1'b1 && t_on < 3000)
    begin
      nxt(1);
      t_on++;
    end
    check("uv during ramp", {15'h0, uv}, 16'h0000);
    check("switching", {15'h0, sw}, 16'h0001);
    while (ramp === 1'b1 && t_len < 3000)
    begin
      nxt(1);
      t_len++;
    end
    if (t_on >= 3000 || t_len >= 3000)
    begin
      err_count++;
      $display("MISMATCH ramp_wait expected 1 seen 0");
      test_done();
    end
  endtask

  task automatic stop;
    start = 1'b0;
    nxt(2);
    check("idle outputs", {12'h0, sw, ramp, uv, 1'b0}, 16'h0000);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    nxt(2);
    i_nrst = 1'b1;
    nxt(2);
    rdchk("delay reset", 8'h60, 16'hF800);
    rdchk("ramp reset", 8'h61, 16'hF00C);
    rdchk("timeout reset", 8'h62, 16'hF800);
    rdchk("unmapped read", 8'h63, 16'h0000);
    $display("Test reset_values done");

    for (int i = 0; i < 9; i++)
    begin
      u_host_model.wr(wc[i], ww[i]);
      nxt(1);
      check("refused flag", {15'h0, s_cml}, {15'h0, wbad[i]});
      check("alert", {15'h0, alert}, {15'h0, wbad[i]});
      if (!wbad[i])
        regv[wc[i][1:0]] = ww[i];
      rdchk("readback", wc[i], regv[wc[i][1:0]]);
      pulse_clr();
    end
    check("flag cleared", {15'h0, s_cml}, 16'h0000);
    $display("Test write_ranges done");

    restore = 1'b1;
    nxt(1);
    restore = 1'b0;
    nxt(2);
    rdchk("restored delay", 8'h60, 16'hF802);
    $display("Test restore done");

    for (int i = 0; i < 3; i++)
    begin
      u_host_model.wr(8'h60, sd[i]);
      u_host_model.wr(8'h61, sr[i]);
      target = st[i];
      nxt(1);
      run(st[i]);
      inr("ramp start", t_on, on_lo[i], on_hi[i]);
      inr("ramp length", t_len, ln_lo[i], ln_hi[i]);
      check("ref at end", ref_dac, st[i]);
      check("uv armed", {15'h0, uv}, 16'h0001);
      stop();
    end
    $display("Test sequencing done");

    target = 16'h0014;
    u_host_model.wr(8'h61, 16'hF000);
    for (int i = 0; i < 5; i++)
    begin
      u_host_model.wr(8'h62, tl[i]);
      resp = tr[i];
      nxt(1);
      run(tt[i]);
      check("not early", {15'h0, s_to}, 16'h0000);
      nxt(50);
      check("fault bits", {12'h0, s_oth, s_vout, s_to, alert},
            {12'h0, {4{tf[i]}}});
      check("shut early", {15'h0, shut}, {15'h0, te[i]});
      nxt(90);
      check("shut late", {15'h0, shut}, {15'h0, tz[i]});
      stop();
      pulse_clr();
    end
    $display("Test startup_timeout done");
    test_done();
  end
endmodule // startup_delay_ramp_timeout_tb_top
`default_nettype wire
